// file: design/hjs_pkg.sv
/*
  Shared constants and types of the homing and jog sequencer: register map,
  field positions, reset values, error codes and carrier structs.
  Assumes a 32-bit AHB-Lite register bus and active-high internal input levels.
*/
package hjs_pkg;
  localparam int SPD_W = 27;
  localparam int RATE_W = 16;
  localparam int IDX_W = 4;
  localparam int TBL_N = 16;
  localparam int ST_W = 5;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OFFS = 8'h04;
  localparam logic [7:0] A_ACC = 8'h08;
  localparam logic [7:0] A_DEC = 8'h0C;
  localparam logic [7:0] A_HSPD = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_STATE = 8'h1C;
  localparam logic [7:0] A_POS = 8'h20;
  localparam logic [7:0] A_SAVE = 8'h24;
  localparam logic [7:0] A_ERR = 8'h28;
  localparam logic [1:0] A_TBL_HI = 2'h1;

  localparam int CTRL_DIR = 2;
  localparam int CTRL_ABS = 3;
  localparam int ST_DONE = 0;
  localparam int ST_CFG = 1;
  localparam int ST_ENC = 2;
  localparam int ST_CANC = 3;
  localparam int ST_SAVE = 4;

  localparam logic [1:0] METH_NONE = 2'h0;
  localparam logic [1:0] METH_BOTH = 2'h1;
  localparam logic [1:0] METH_DEC = 2'h2;
  localparam logic [1:0] METH_IDX = 2'h3;

  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CFG = 16'hE5DE;
  localparam logic [15:0] ERR_ENC = 16'hE61E;

  localparam logic [SPD_W-1:0] SPD_MIN = 27'h0000001;
  localparam logic [SPD_W-1:0] SPD_MAX = 27'h5F5E0FF;
  localparam logic [SPD_W-1:0] SPD_RST = 27'h00003E8;
  localparam logic [RATE_W-1:0] RATE_RST = 16'h03E8;
  localparam logic [31:0] OFFS_RST = 32'h00000000;
  localparam logic [IDX_W-1:0] TBL_LAST = 4'hF;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    CMD_STOP = 2'h0,
    CMD_HOME = 2'h1,
    CMD_FWD = 2'h2,
    CMD_REV = 2'h3
  } hjs_cmd_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SEEK = 4'h2,
    HS_CREEP = 4'h4,
    HS_PAUSE = 4'h8
  } hjs_hstate_t;

  typedef struct packed {
    logic home;
    logic fwd;
    logic rev;
    logic [1:0] mode;
    logic [IDX_W-1:0] sel;
    logic dec;
    logic index;
  } hjs_in_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic homing;
    logic [SPD_W-1:0] speed;
    logic [RATE_W-1:0] accel;
    logic [RATE_W-1:0] decel;
  } hjs_motion_t;

  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] addr;
    logic [SPD_W-1:0] data;
  } hjs_flash_t;
endpackage

// file: design/hjs_sync.sv
/*
  Two-flop synchroniser, one chain per bit.
  Assumes nothing reads the first flop except the second.
*/
`timescale 1ns/1ps
module hjs_sync #(
  parameter int W = 11
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        meta_r[i] <= 1'b0;
        q_o[i] <= 1'b0;
      end else begin
        meta_r[i] <= d_i[i];
        q_o[i] <= meta_r[i];
      end
    end
  end
endmodule // hjs_sync

// file: design/hjs_speed_table.sv
/*
  Jog speed table storage: one write port, every entry visible.
  Assumes the caller has range-checked the write data.
*/
`timescale 1ns/1ps
module hjs_speed_table #(
  parameter int N = 16,
  parameter int IW = 4,
  parameter int W = 27,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic we_i,
  input wire logic [IW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] tbl_o [N]
);
  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        tbl_o[i] <= RST;
      end else if (we_i && waddr_i == IW'(i)) begin
        tbl_o[i] <= wdata_i;
      end
    end
  end
endmodule // hjs_speed_table

// file: design/hjs_top.sv
/*
  Homing and jog sequencer with AHB-Lite register slave, sticky status with
  interrupt, jog speed table and flash save walker.
  Assumes host inputs are active-high levels; flash_busy_i may rise one cycle
  after a write strobe.
*/
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Home request rising starts homing
// [RULE_02] Home request dropping pauses homing
// [RULE_03] Home request again resumes paused phase
// [RULE_04] Jog or mode change cancels paused homing
// [RULE_05] Method zero: homed right after power-up
// [RULE_06] Homing ramp is min of accel, decel
// [RULE_07] Method zero refuses home, raises E5DE
// [RULE_08] Absolute encoder refuses home, raises E61E
// [RULE_09] Method one: limit switch then index
// [RULE_10] Forward jog forward, reverse jog reverse
// [RULE_11] Sixteen independently programmable jog speeds
// [RULE_12] Four select bits form binary index
// [RULE_13] Speeds 1..99999999, default 1000
// [RULE_14] Save command writes table to flash
// [RULE_15] Exactly one request acts, else stop
// [RULE_16] Method two switch only, three index
// [RULE_17] Direction setting picks homing direction
// [RULE_18] Homing completion loads home offset position
// [RULE_19] Synchronise host inputs before decoding
module hjs_top
  import hjs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic home_request_i,
  input wire logic jog_forward_request_i,
  input wire logic jog_reverse_request_i,
  input wire logic [1:0] mode_select_i,
  input wire logic speed_select_bit0_i,
  input wire logic speed_select_bit1_i,
  input wire logic speed_select_bit2_i,
  input wire logic speed_select_bit3_i,
  input wire logic decel_limit_switch_i,
  input wire logic encoder_index_i,
  input wire logic flash_busy_i,
  output hjs_flash_t flash_o,
  output hjs_motion_t motion_o,
  output logic [31:0] position_o,
  output logic [15:0] error_code_o,
  output logic homed_o,
  output logic irq_o
);
  hjs_in_t in_raw;
  hjs_in_t in_s;
  logic acc;
  logic [7:0] a_addr_r;
  logic wr_r;
  logic rd_r;
  logic hrdy_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic [1:0] meth_r;
  logic dir_r;
  logic abs_r;
  logic [31:0] offs_r;
  logic [RATE_W-1:0] acc_r;
  logic [RATE_W-1:0] dec_r;
  logic [SPD_W-1:0] hspd_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] stat_r;
  logic [ST_W-1:0] stat_nxt;
  logic [ST_W-1:0] ev;
  logic irq_r;
  logic spd_ok;
  logic tbl_we;
  logic [SPD_W-1:0] tbl [TBL_N];
  hjs_cmd_t cmd;
  hjs_cmd_t cmd_q_r;
  logic home_rise;
  logic bad_enc;
  logic bad_cfg;
  logic home_ok;
  hjs_hstate_t hst_r;
  logic resume_r;
  logic [1:0] mode_p_r;
  logic pause_go;
  logic seek_hit;
  logic done_ev;
  logic cancel_ev;
  logic pwr_r;
  logic pwr_done;
  logic homed_r;
  logic [31:0] pos_r;
  logic [15:0] err_r;
  logic [RATE_W-1:0] hrate;
  hjs_motion_t motion_r;
  logic saving_r;
  logic [IDX_W-1:0] fa_r;
  hjs_flash_t flash_r;
  logic save_go;
  logic issue;
  logic save_ev;

  assign in_raw = {home_request_i, jog_forward_request_i, jog_reverse_request_i, mode_select_i,
                   speed_select_bit3_i, speed_select_bit2_i, speed_select_bit1_i, speed_select_bit0_i,
                   decel_limit_switch_i, encoder_index_i};

  // Mixed states during input transitions are only seen after this point
  hjs_sync #(.W($bits(hjs_in_t))) u_sync ( // RULE_19
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .d_i(in_raw),
    .q_o(in_s)
  );

  // Bus slave: writes are zero-wait, reads take one wait state so that a read
  // right after a write already sees the written value.
  assign acc = hsel_i & htrans_i[1] & hready_i;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_addr_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      if (acc) begin
        a_addr_r <= haddr_i[7:0];
      end
      wr_r <= acc & hwrite_i & (hsize_i == HSIZE_WORD);
      rd_r <= acc & ~hwrite_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdy_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else if (acc && !hwrite_i) begin
      hrdy_r <= 1'b0;
    end else if (rd_r) begin
      hrdy_r <= 1'b1;
      hrdata_r <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (a_addr_r[7:6] == A_TBL_HI) begin
      rd_mux = {5'h00, tbl[a_addr_r[5:2]]};
    end else begin
      unique case (a_addr_r)
        A_CTRL: rd_mux = {28'h0000000, abs_r, dir_r, meth_r};
        A_OFFS: rd_mux = offs_r;
        A_ACC: rd_mux = {16'h0000, acc_r};
        A_DEC: rd_mux = {16'h0000, dec_r};
        A_HSPD: rd_mux = {5'h00, hspd_r};
        A_STAT: rd_mux = {27'h0000000, stat_r};
        A_MASK: rd_mux = {27'h0000000, mask_r};
        A_STATE: rd_mux = {20'h00000, in_s.sel, saving_r, resume_r, homed_r, 1'b0, hst_r};
        A_POS: rd_mux = pos_r;
        A_ERR: rd_mux = {16'h0000, err_r};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Out-of-range speeds are dropped so the table never holds a bad entry
  assign spd_ok = (hwdata_i >= {5'h00, SPD_MIN}) && (hwdata_i <= {5'h00, SPD_MAX}); // RULE_13

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meth_r <= METH_NONE;
      dir_r <= 1'b0;
      abs_r <= 1'b0;
    end else if (wr_r && a_addr_r == A_CTRL) begin
      meth_r <= hwdata_i[1:0];
      dir_r <= hwdata_i[CTRL_DIR];
      abs_r <= hwdata_i[CTRL_ABS];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      offs_r <= OFFS_RST;
      acc_r <= RATE_RST;
      dec_r <= RATE_RST;
      hspd_r <= SPD_RST;
      mask_r <= '0;
    end else if (wr_r) begin
      if (a_addr_r == A_OFFS) begin
        offs_r <= hwdata_i;
      end
      if (a_addr_r == A_ACC) begin
        acc_r <= hwdata_i[RATE_W-1:0];
      end
      if (a_addr_r == A_DEC) begin
        dec_r <= hwdata_i[RATE_W-1:0];
      end
      if (a_addr_r == A_HSPD && spd_ok) begin
        hspd_r <= hwdata_i[SPD_W-1:0];
      end
      if (a_addr_r == A_MASK) begin
        mask_r <= hwdata_i[ST_W-1:0];
      end
    end
  end

  // Edits are refused during a save so the flash image is one consistent set
  assign tbl_we = wr_r && a_addr_r[7:6] == A_TBL_HI && spd_ok && !saving_r; // RULE_11

  hjs_speed_table #(
    .N(TBL_N),
    .IW(IDX_W),
    .W(SPD_W),
    .RST(SPD_RST)
  ) u_table (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .we_i(tbl_we),
    .waddr_i(a_addr_r[5:2]),
    .wdata_i(hwdata_i[SPD_W-1:0]),
    .tbl_o(tbl)
  );

  always_comb begin
    unique case ({in_s.home, in_s.fwd, in_s.rev})
      3'b100: cmd = CMD_HOME; // RULE_15
      3'b010: cmd = CMD_FWD;
      3'b001: cmd = CMD_REV;
      default: cmd = CMD_STOP;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_q_r <= CMD_STOP;
    end else begin
      cmd_q_r <= cmd;
    end
  end

  assign home_rise = (cmd == CMD_HOME) && (cmd_q_r != CMD_HOME);
  assign bad_enc = home_rise && abs_r; // RULE_08
  assign bad_cfg = home_rise && !abs_r && meth_r == METH_NONE; // RULE_07
  assign home_ok = home_rise && !abs_r && meth_r != METH_NONE;

  assign pause_go = (hst_r == HS_SEEK || hst_r == HS_CREEP) && cmd != CMD_HOME; // RULE_02

  always_comb begin
    unique case (meth_r)
      METH_BOTH: seek_hit = in_s.dec; // RULE_09
      METH_DEC: seek_hit = in_s.dec; // RULE_16
      METH_IDX: seek_hit = in_s.index; // RULE_16
      default: seek_hit = 1'b0;
    endcase
  end

  assign done_ev = !pause_go && ((hst_r == HS_SEEK && seek_hit && meth_r != METH_BOTH) ||
                                 (hst_r == HS_CREEP && in_s.index));
  assign cancel_ev = hst_r == HS_PAUSE && !home_ok &&
                     (in_s.fwd || in_s.rev || in_s.mode != mode_p_r); // RULE_04

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hst_r <= HS_IDLE;
      resume_r <= 1'b0;
      mode_p_r <= 2'h0;
    end else begin
      unique case (hst_r)
        HS_IDLE: begin
          if (home_ok) begin
            hst_r <= HS_SEEK; // RULE_01
          end
        end
        HS_SEEK: begin
          if (pause_go) begin
            hst_r <= HS_PAUSE;
            resume_r <= 1'b0;
            mode_p_r <= in_s.mode;
          end else if (done_ev) begin
            hst_r <= HS_IDLE;
          end else if (seek_hit) begin
            hst_r <= HS_CREEP; // RULE_09
          end
        end
        HS_CREEP: begin
          if (pause_go) begin
            hst_r <= HS_PAUSE;
            resume_r <= 1'b1;
            mode_p_r <= in_s.mode;
          end else if (done_ev) begin
            hst_r <= HS_IDLE;
          end
        end
        HS_PAUSE: begin
          if (home_ok) begin
            hst_r <= resume_r ? HS_CREEP : HS_SEEK; // RULE_03
          end else if (cancel_ev) begin
            hst_r <= HS_IDLE; // RULE_04
          end
        end
        default: hst_r <= HS_IDLE;
      endcase
    end
  end

  // Method zero counts as homed once, on the first cycle after reset
  assign pwr_done = !pwr_r && meth_r == METH_NONE; // RULE_05

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_r <= 1'b0;
      homed_r <= 1'b0;
      pos_r <= OFFS_RST;
    end else begin
      pwr_r <= 1'b1;
      if (pwr_done || done_ev) begin
        homed_r <= 1'b1;
        pos_r <= offs_r; // RULE_18
      end else if (hst_r == HS_IDLE && home_ok) begin
        homed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_r <= ERR_NONE;
    end else if (bad_enc) begin
      err_r <= ERR_ENC; // RULE_08
    end else if (bad_cfg) begin
      err_r <= ERR_CFG; // RULE_07
    end
  end

  assign hrate = (acc_r < dec_r) ? acc_r : dec_r; // RULE_06

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      motion_r <= '0;
    end else if (hst_r == HS_SEEK || hst_r == HS_CREEP) begin
      motion_r <= '{run: 1'b1, reverse: dir_r, homing: 1'b1, speed: hspd_r, // RULE_17
                    accel: hrate, decel: hrate}; // RULE_06
    end else if (hst_r == HS_IDLE && (cmd == CMD_FWD || cmd == CMD_REV)) begin
      motion_r <= '{run: 1'b1, reverse: cmd == CMD_REV, homing: 1'b0, // RULE_10
                    speed: tbl[in_s.sel], accel: acc_r, decel: dec_r}; // RULE_12
    end else begin
      motion_r <= '{run: 1'b0, reverse: 1'b0, homing: 1'b0, speed: '0, // RULE_15
                    accel: acc_r, decel: dec_r};
    end
  end

  // Flash walker: one entry per strobe, waits out busy between strobes
  assign save_go = wr_r && a_addr_r == A_SAVE && hwdata_i[0] && !saving_r;
  assign issue = saving_r && !flash_busy_i && !flash_r.we;
  assign save_ev = issue && fa_r == TBL_LAST;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      saving_r <= 1'b0;
      fa_r <= '0;
    end else if (save_go) begin
      saving_r <= 1'b1; // RULE_14
      fa_r <= '0;
    end else if (issue) begin
      fa_r <= fa_r + 4'h1;
      if (fa_r == TBL_LAST) begin
        saving_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_r <= '0;
    end else begin
      flash_r.we <= issue; // RULE_14
      if (issue) begin
        flash_r.addr <= fa_r;
        flash_r.data <= tbl[fa_r];
      end
    end
  end

  // A new event in the clearing cycle survives the read clear
  assign ev = {save_ev, cancel_ev, bad_enc, bad_cfg, done_ev | pwr_done};
  assign stat_nxt = ((rd_r && a_addr_r == A_STAT) ? '0 : stat_r) | ev;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hrdy_r;
  assign hresp_o = 1'b0 & hrdy_r;
  assign flash_o = flash_r;
  assign motion_o = motion_r;
  assign position_o = pos_r;
  assign error_code_o = err_r;
  assign homed_o = homed_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_start;
    hst_r == HS_IDLE && home_ok |=> hst_r == HS_SEEK ##1 motion_r.run && motion_r.homing;
  endproperty
  a_start: assert property (p_start) else $error("home request did not start homing"); // RULE_01

  property p_pause;
    pause_go |=> hst_r == HS_PAUSE ##1 !motion_r.run;
  endproperty
  a_pause: assert property (p_pause) else $error("homing did not pause"); // RULE_02

  property p_resume;
    hst_r == HS_PAUSE && home_ok |=> hst_r == (resume_r ? HS_CREEP : HS_SEEK);
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not return to interrupted phase"); // RULE_03

  property p_cancel;
    hst_r == HS_PAUSE && !home_ok && (in_s.fwd || in_s.rev) |=> hst_r == HS_IDLE && stat_r[ST_CANC];
  endproperty
  a_cancel: assert property (p_cancel) else $error("paused homing not cancelled"); // RULE_04

  property p_pwr;
    !pwr_r && meth_r == METH_NONE |=> homed_r && stat_r[ST_DONE];
  endproperty
  a_pwr: assert property (p_pwr) else $error("method zero not homed at power-up"); // RULE_05

  property p_ramp;
    motion_r.homing |-> motion_r.accel == motion_r.decel &&
      motion_r.accel == (($past(acc_r) < $past(dec_r)) ? $past(acc_r) : $past(dec_r));
  endproperty
  a_ramp: assert property (p_ramp) else $error("homing ramp is not the smaller rate"); // RULE_06

  property p_cfg;
    bad_cfg |=> err_r == ERR_CFG && stat_r[ST_CFG] && hst_r != HS_SEEK;
  endproperty
  a_cfg: assert property (p_cfg) else $error("method zero home not refused"); // RULE_07

  property p_enc;
    bad_enc |=> err_r == ERR_ENC && stat_r[ST_ENC] && hst_r != HS_SEEK;
  endproperty
  a_enc: assert property (p_enc) else $error("absolute encoder home not refused"); // RULE_08

  property p_both;
    hst_r == HS_SEEK && !pause_go && meth_r == METH_BOTH && in_s.dec |=> hst_r == HS_CREEP;
  endproperty
  a_both: assert property (p_both) else $error("limit switch did not lead to index search"); // RULE_09

  property p_jog;
    hst_r == HS_IDLE && cmd == CMD_FWD |=> motion_r.run && !motion_r.reverse &&
      motion_r.speed == $past(tbl[in_s.sel]);
  endproperty
  a_jog: assert property (p_jog) else $error("forward jog output wrong"); // RULE_10

  property p_stop;
    cmd == CMD_STOP && (hst_r == HS_IDLE || hst_r == HS_PAUSE) |=> !motion_r.run;
  endproperty
  a_stop: assert property (p_stop) else $error("mixed requests did not stop"); // RULE_15

  property p_offs;
    done_ev |=> pos_r == $past(offs_r) && homed_r;
  endproperty
  a_offs: assert property (p_offs) else $error("position not loaded with offset"); // RULE_18

  property p_save;
    issue |=> flash_r.we ##1 !flash_r.we;
  endproperty
  a_save: assert property (p_save) else $error("flash strobe not one cycle"); // RULE_14

  c_home_done: cover property (hst_r == HS_CREEP ##1 done_ev);
  c_resume: cover property (hst_r == HS_PAUSE ##1 hst_r == HS_CREEP);
  c_cancel: cover property (cancel_ev);
  c_save: cover property (save_ev);
endmodule // hjs_top

// file: testbench/hjs_host_model.sv
/*
  Host controller model: turns a command code into the three request levels.
  Assumes the bench changes its command just after a rising edge.
*/
`timescale 1ns/1ps
module hjs_host_model
  import hjs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire hjs_cmd_t cmd_i,
  input wire logic both_i,
  output logic home_o,
  output logic fwd_o,
  output logic rev_o
);
  // Registered, so the levels move only on a rising edge, one cycle after the command
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      home_o <= 1'b0;
      fwd_o <= 1'b0;
      rev_o <= 1'b0;
    end else begin
      home_o <= (cmd_i == CMD_HOME);
      fwd_o <= (cmd_i == CMD_FWD) || both_i;
      rev_o <= (cmd_i == CMD_REV) || both_i;
    end
  end
endmodule // hjs_host_model

// file: testbench/homing_jog_sequencer_tb_top.sv
/*
  Self-checking bench of the homing and jog sequencer: AHB-Lite register tasks,
  host model on the request pins, flash busy echo.
  Assumes two-flop input sync and one read wait state.
*/
`timescale 1ns/1ps
module homing_jog_sequencer_tb_top;
  import hjs_pkg::*;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, home, fwd, rev, both, dec, idx, busy, homed, irq;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [3:0] sel;
  logic [31:0] haddr, hwdata, hrdata, pos, d;
  logic [15:0] err;
  hjs_cmd_t cmd;
  hjs_flash_t fl;
  hjs_motion_t mo;
  int fail_count, n_compared, ticks, nwe;

  hjs_top uut (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .home_request_i(home), .jog_forward_request_i(fwd),
    .jog_reverse_request_i(rev), .mode_select_i(mode), .speed_select_bit0_i(sel[0]),
    .speed_select_bit1_i(sel[1]), .speed_select_bit2_i(sel[2]), .speed_select_bit3_i(sel[3]),
    .decel_limit_switch_i(dec), .encoder_index_i(idx), .flash_busy_i(busy), .flash_o(fl),
    .motion_o(mo), .position_o(pos), .error_code_o(err), .homed_o(homed), .irq_o(irq));
  hjs_host_model host (.core_clk_i(clk), .rstn_i(rstn), .cmd_i(cmd), .both_i(both),
    .home_o(home), .fwd_o(fwd), .rev_o(rev));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Flash writer stays busy one cycle after each strobe
  always @(posedge clk) busy <= fl.we;

  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, d);
    chk(d, e);
  endtask

  task automatic st(input logic [3:0] e);
    bus(1'b0, A_STATE, 32'h00000000, d);
    chk({28'h0000000, d[3:0]}, {28'h0000000, e});
  endtask

  initial begin
    {hsel, hwrite, both, dec, idx, mode, sel, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    cmd = CMD_STOP;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
    chk(homed, 32'h1);
    rchk(A_STAT, 32'h1);
    chk(hresp, 32'h0);
    rchk(A_HSPD, 32'h3E8);
    rchk(8'h7C, 32'h3E8);
    $display("test reset done");
    cmd <= CMD_HOME;
    cyc(6);
    rchk(A_ERR, 32'hE5DE);
    chk(err, 32'hE5DE);
    chk(mo.run, 32'h0);
    cmd <= CMD_STOP;
    wr(A_CTRL, 32'h9);
    cmd <= CMD_HOME;
    cyc(6);
    rchk(A_ERR, 32'hE61E);
    chk(err, 32'hE61E);
    cmd <= CMD_STOP;
    rchk(A_STAT, 32'h6);
    $display("test refusals done");
    wr(A_ACC, 32'hC8);
    wr(A_DEC, 32'h64);
    wr(A_OFFS, 32'h1234);
    wr(A_CTRL, 32'h5);
    wr(A_MASK, 32'h1);
    cmd <= CMD_HOME;
    cyc(6);
    chk({mo.run, mo.homing, mo.reverse}, 32'h7);
    chk({mo.accel, mo.decel}, 32'h00640064);
    dec <= 1'b1;
    cyc(6);
    st(4'h4);
    cmd <= CMD_STOP;
    cyc(6);
    st(4'h8);
    chk(mo.run, 32'h0);
    cmd <= CMD_HOME;
    cyc(6);
    st(4'h4);
    idx <= 1'b1;
    cyc(4);
    idx <= 1'b0;
    cyc(4);
    chk(homed, 32'h1);
    chk(pos, 32'h1234);
    chk(irq, 32'h1);
    rchk(A_STAT, 32'h1);
    cyc(2);
    chk(irq, 32'h0);
    cmd <= CMD_STOP;
    dec <= 1'b0;
    cyc(6);
    // Method two finishes on the switch alone, three on the index alone
    for (int m = 2; m < 4; m++) begin
      wr(A_CTRL, 32'(m));
      cmd <= CMD_HOME;
      cyc(6);
      chk({mo.run, mo.homing, mo.reverse}, 32'h6);
      if (m == 2) dec <= 1'b1;
      else idx <= 1'b1;
      cyc(6);
      {dec, idx} <= 2'b00;
      rchk(A_STAT, 32'h1);
      cmd <= CMD_STOP;
      cyc(6);
    end
    $display("test homing done");
    wr(A_CTRL, 32'h1);
    for (int j = 0; j < 2; j++) begin
      cmd <= CMD_HOME;
      cyc(6);
      cmd <= CMD_STOP;
      cyc(6);
      if (j == 0) cmd <= CMD_FWD;
      else mode <= 2'h1;
      cyc(6);
      rchk(A_STAT, 32'h8);
      cmd <= CMD_STOP;
      cyc(6);
    end
    $display("test cancel done");
    wr(8'h54, 32'h1234);
    wr(8'h54, 32'h0);
    rchk(8'h54, 32'h1234);
    sel <= 4'h5;
    cmd <= CMD_FWD;
    cyc(6);
    chk({mo.run, mo.reverse, mo.speed}, {2'b10, 27'h1234});
    sel <= 4'hF;
    cmd <= CMD_REV;
    cyc(6);
    chk({mo.run, mo.reverse, mo.speed}, {2'b11, SPD_RST});
    both <= 1'b1;
    cyc(6);
    chk(mo.run, 32'h0);
    both <= 1'b0;
    cmd <= CMD_STOP;
    $display("test jog done");
    wr(A_SAVE, 32'h1);
    nwe = 0;
    repeat (200) begin
      @(posedge clk);
      if (fl.we === 1'b1) begin
        chk(fl.addr, nwe);
        if (nwe == 5) chk(fl.data, 32'h1234);
        nwe++;
      end
    end
    chk(nwe, 32'h10);
    rchk(A_STAT, 32'h10);
    $display("test save done");
    tally_and_finish();
  end
endmodule // homing_jog_sequencer_tb_top
